// *** hdl/spisd_core.v ***
/*
 * Status flags, shared data register and receive buffering of a serial
 * peripheral interface, with a minimal mode-0 shift engine, MSB first.
 * Assumes a byte-wide register port on clk, link pins from outside the
 * clk domain, and a slave select that rises between words in slave mode.
 */
`timescale 1ns/1ps
`include "spisd_defs.vh"

// Contract
// - receive-complete flag in status bit 7 set after data lands in register
// - transmit-empty flag in bit 5 high while transmit register accepts data
// - mode-fault flag bit 4 set when select goes low as detecting master
// - status read seeing mode fault, then control one write, clears it
// - status readable anytime, writes to it change nothing
// - low byte read after status read seeing receive flag clears it
// - high byte reads never touch the receive flag
// - low byte write after status read seeing empty flag clears it
// - data writes ignored while transmit-empty flag is zero
// - high byte writes never touch the transmit-empty flag
// - high byte at 4, low at 5, high resets zero, both accessible
// - master starts queued data right after previous transfer ends
// - word received with flag clear is copied in and flag set
// - word received with flag set held in shifter until next start
// - flag serviced before third start moves held word in, flag stays
// - flag serviced after third start discards the held word
// - width bit in control two picks eight or sixteen bit transfers
module spisd_core #(
    parameter [7:0] HALF_DIV = `SPISD_HALF_DIV
) (
    input  wire       clk,
    input  wire       rst,
    input  wire [2:0] bus_addr,
    input  wire [7:0] bus_wdata,
    input  wire       bus_wr,
    input  wire       bus_rd,
    output reg  [7:0] bus_rdata,
    input  wire       sck_in,
    output reg        sck_out,
    output wire       sck_oe_n,
    input  wire       mosi_in,
    output wire       mosi_out,
    output wire       mosi_oe_n,
    input  wire       miso_in,
    output wire       miso_out,
    output wire       miso_oe_n,
    input  wire       ss_n_in,
    output wire       transfer_busy
);

    localparam [1:0] ST_IDLE   = 2'd0;
    localparam [1:0] ST_MASTER = 2'd1;
    localparam [1:0] ST_SLAVE  = 2'd2;

    function [4:0] xfer_bits;
        input wide;
        begin
            xfer_bits = wide ? `SPISD_BITS_WIDE : `SPISD_BITS_NARROW;
        end
    endfunction

    function [15:0] fit_word;
        input        wide;
        input [15:0] word;
        begin
            fit_word = wide ? word : {8'h00, word[7:0]};
        end
    endfunction

    reg  [7:0]  control_register_one;
    reg  [7:0]  control_register_two;
    reg         receive_complete_flag;
    reg         transmit_empty_flag;
    reg         mode_fault_flag;
    reg         rcf_armed;
    reg         tef_armed;
    reg         mode_fault_flag_armed;
    reg  [7:0]  tx_high;
    reg  [7:0]  tx_low;
    reg  [15:0] serial_data_word;
    reg  [15:0] held_word;
    reg         held_valid;

    reg  [1:0]  state;
    reg  [7:0]  div_cnt;
    reg  [4:0]  bit_cnt;
    reg  [15:0] tx_sh;
    reg  [15:0] rx_sh;
    reg         xfer_done;
    reg  [15:0] done_word;

    reg         sck_s1;
    reg         sck_s2;
    reg         sck_s3;
    reg         ss_s1;
    reg         ss_s2;
    reg         ss_s3;
    reg         mosi_s1;
    reg         mosi_s2;
    reg         miso_s1;
    reg         miso_s2;

    wire enable   = control_register_one[`SPISD_C1_ENABLE];
    wire master   = control_register_one[`SPISD_C1_MASTER];
    wire wide     = control_register_two[`SPISD_C2_WIDTH];
    wire mf_det   = control_register_two[`SPISD_C2_MFDET];
    wire [4:0] nbits = xfer_bits(wide);

    wire sck_rise = sck_s2 & ~sck_s3;
    wire sck_fall = ~sck_s2 & sck_s3;
    wire ss_fall  = ~ss_s2 & ss_s3;

    wire mode_fault_now = enable & master & mf_det & ~ss_s2;

    // queued word leaves as soon as the engine is idle again
    wire master_go = (state == ST_IDLE) & enable & master &
                     ~transmit_empty_flag & ~mode_fault_now;
    wire slave_go  = (state == ST_IDLE) & enable & ~master & ss_fall;
    wire xfer_start = master_go | slave_go;

    wire wr_ctrl_one = bus_wr & (bus_addr == `SPISD_OFS_CTRL_ONE);
    wire wr_ctrl_two = bus_wr & (bus_addr == `SPISD_OFS_CTRL_TWO);
    wire wr_high     = bus_wr & (bus_addr == `SPISD_OFS_DATA_HIGH);
    wire wr_low      = bus_wr & (bus_addr == `SPISD_OFS_DATA_LOW);
    wire rd_status   = bus_rd & (bus_addr == `SPISD_OFS_STATUS);
    wire rd_low      = bus_rd & (bus_addr == `SPISD_OFS_DATA_LOW);

    wire clear_rcf  = rd_low & rcf_armed & receive_complete_flag;
    wire clear_tef  = wr_low & tef_armed & transmit_empty_flag;
    wire clear_mode_fault_flag = wr_ctrl_one & mode_fault_flag_armed & mode_fault_flag;

    wire out_bit = wide ? tx_sh[15] : tx_sh[7];

    assign sck_oe_n      = ~(enable & master);
    assign mosi_oe_n     = ~(enable & master);
    assign mosi_out      = out_bit;
    // slave output is released whenever it is not selected
    assign miso_oe_n     = ~(enable & ~master & ~ss_s2);
    assign miso_out      = out_bit;
    assign transfer_busy = (state != ST_IDLE);

    // pin synchronisers; logic takes the second stage, and the sck and select edge detects also use a third
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            sck_s1  <= 1'b0;
            sck_s2  <= 1'b0;
            sck_s3  <= 1'b0;
            ss_s1   <= 1'b1;
            ss_s2   <= 1'b1;
            ss_s3   <= 1'b1;
            mosi_s1 <= 1'b0;
            mosi_s2 <= 1'b0;
            miso_s1 <= 1'b0;
            miso_s2 <= 1'b0;
        end else begin
            sck_s1  <= sck_in;
            sck_s2  <= sck_s1;
            sck_s3  <= sck_s2;
            ss_s1   <= ss_n_in;
            ss_s2   <= ss_s1;
            ss_s3   <= ss_s2;
            mosi_s1 <= mosi_in;
            mosi_s2 <= mosi_s1;
            miso_s1 <= miso_in;
            miso_s2 <= miso_s1;
        end
    end

    // shift engine, mode 0: sample on rising clock, shift on falling
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state     <= ST_IDLE;
            div_cnt   <= 8'h00;
            bit_cnt   <= 5'h00;
            tx_sh     <= 16'h0000;
            rx_sh     <= 16'h0000;
            sck_out   <= 1'b0;
            xfer_done <= 1'b0;
            done_word <= 16'h0000;
        end else begin
            xfer_done <= 1'b0;
            case (state)
            ST_IDLE: begin
                sck_out <= 1'b0;
                div_cnt <= 8'h00;
                bit_cnt <= 5'h00;
                if (xfer_start) begin
                    tx_sh <= fit_word(wide, {tx_high, tx_low});
                    rx_sh <= 16'h0000;
                    state <= master_go ? ST_MASTER : ST_SLAVE;
                end
            end
            ST_MASTER: begin
                // a fault or disable aborts without delivering a word
                if (mode_fault_now | ~enable | ~master) begin
                    state   <= ST_IDLE;
                    sck_out <= 1'b0;
                end else if (div_cnt == HALF_DIV - 8'h01) begin
                    div_cnt <= 8'h00;
                    if (!sck_out) begin
                        sck_out <= 1'b1;
                        rx_sh   <= {rx_sh[14:0], miso_s2};
                        bit_cnt <= bit_cnt + 5'h01;
                    end else begin
                        sck_out <= 1'b0;
                        if (bit_cnt == nbits) begin
                            state     <= ST_IDLE;
                            xfer_done <= 1'b1;
                            done_word <= fit_word(wide, rx_sh);
                        end else begin
                            tx_sh <= {tx_sh[14:0], 1'b0};
                        end
                    end
                end else begin
                    div_cnt <= div_cnt + 8'h01;
                end
            end
            ST_SLAVE: begin
                // deselect mid-word forces idle and drops the partial word
                if (ss_s2 | ~enable | master) begin
                    state <= ST_IDLE;
                end else if (sck_rise) begin
                    rx_sh   <= {rx_sh[14:0], mosi_s2};
                    bit_cnt <= bit_cnt + 5'h01;
                    if (bit_cnt + 5'h01 == nbits) begin
                        state     <= ST_IDLE;
                        xfer_done <= 1'b1;
                        done_word <= fit_word(wide, {rx_sh[14:0], mosi_s2});
                    end
                end else if (sck_fall) begin
                    tx_sh <= {tx_sh[14:0], 1'b0};
                end
            end
            default: begin
                state <= ST_IDLE;
            end
            endcase
        end
    end

    // control registers, flags and the shared data register
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            control_register_one  <= `SPISD_RST_CTRL_ONE;
            control_register_two  <= `SPISD_RST_CTRL_TWO;
            receive_complete_flag <= 1'b0;
            transmit_empty_flag   <= 1'b1;
            mode_fault_flag       <= 1'b0;
            rcf_armed             <= 1'b0;
            tef_armed             <= 1'b0;
            mode_fault_flag_armed            <= 1'b0;
            tx_high               <= `SPISD_RST_DATA_HIGH;
            tx_low                <= `SPISD_RST_DATA_LOW;
            serial_data_word      <= {`SPISD_RST_DATA_HIGH,
                                      `SPISD_RST_DATA_LOW};
            held_word             <= 16'h0000;
            held_valid            <= 1'b0;
        end else begin
            if (wr_ctrl_one) begin
                control_register_one <= bus_wdata;
            end
            if (wr_ctrl_two) begin
                control_register_two <= bus_wdata;
            end
            // fault drops master mode; it wins over a same-cycle write
            if (mode_fault_now) begin
                control_register_one[`SPISD_C1_MASTER] <= 1'b0;
            end

            // status register itself ignores writes
            if (rd_status) begin
                rcf_armed  <= receive_complete_flag;
                tef_armed  <= transmit_empty_flag;
                mode_fault_flag_armed <= mode_fault_flag;
            end

            if (mode_fault_now) begin
                mode_fault_flag <= 1'b1;
            end else if (clear_mode_fault_flag) begin
                mode_fault_flag <= 1'b0;
                mode_fault_flag_armed      <= 1'b0;
            end

            // data writes only land while the transmit register is free
            if (wr_high & transmit_empty_flag) begin
                tx_high <= bus_wdata;
            end
            if (wr_low & transmit_empty_flag) begin
                tx_low <= bus_wdata;
            end
            if (clear_tef) begin
                transmit_empty_flag <= 1'b0;
                tef_armed           <= 1'b0;
            end else if (xfer_start & ~transmit_empty_flag) begin
                transmit_empty_flag <= 1'b1;
            end

            if (rd_low) begin
                rcf_armed <= 1'b0;
            end
            // a word arriving with the clear still sets the flag
            if (clear_rcf & held_valid) begin
                serial_data_word      <= held_word;
                receive_complete_flag <= 1'b1;
                held_valid            <= xfer_done;
                if (xfer_done) begin
                    held_word <= done_word;
                end
            end else if (xfer_done & (~receive_complete_flag | clear_rcf)) begin
                serial_data_word      <= done_word;
                receive_complete_flag <= 1'b1;
            end else if (clear_rcf) begin
                receive_complete_flag <= 1'b0;
            end else if (xfer_done) begin
                held_word  <= done_word;
                held_valid <= 1'b1;
            end
            // a new transfer starting makes any held word stale
            if (xfer_start) begin
                held_valid <= 1'b0;
            end
        end
    end

    // register read port, data valid one cycle after the strobe
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            bus_rdata <= 8'h00;
        end else if (bus_rd) begin
            case (bus_addr)
            `SPISD_OFS_CTRL_ONE: begin
                bus_rdata <= control_register_one;
            end
            `SPISD_OFS_CTRL_TWO: begin
                bus_rdata <= control_register_two;
            end
            `SPISD_OFS_STATUS: begin
                bus_rdata <= {receive_complete_flag, 1'b0,
                              transmit_empty_flag, mode_fault_flag,
                              4'h0};
            end
            `SPISD_OFS_DATA_HIGH: begin
                bus_rdata <= serial_data_word[15:8];
            end
            `SPISD_OFS_DATA_LOW: begin
                bus_rdata <= serial_data_word[7:0];
            end
            default: begin
                bus_rdata <= 8'h00;
            end
            endcase
        end else begin
            bus_rdata <= 8'h00;
        end
    end

endmodule // spisd_core

// *** hdl/spisd_defs.vh ***
/*
 * Constants for the serial status and data buffer block: register
 * offsets, field positions, reset values and the link timing count.
 * Assumes it is included by its bare name from the design file.
 */
`ifndef SPISD_DEFS_VH
`define SPISD_DEFS_VH

// register offsets on the byte-wide register port
`define SPISD_OFS_CTRL_ONE    3'h0
`define SPISD_OFS_CTRL_TWO    3'h1
`define SPISD_OFS_STATUS      3'h3
`define SPISD_OFS_DATA_HIGH   3'h4
`define SPISD_OFS_DATA_LOW    3'h5

// control_register_one fields
`define SPISD_C1_ENABLE       6
`define SPISD_C1_MASTER       4

// control_register_two fields
`define SPISD_C2_WIDTH        6
`define SPISD_C2_MFDET        4

// serial_status fields
`define SPISD_SR_RCF          7
`define SPISD_SR_TEF          5
`define SPISD_SR_MODE_FAULT_FLAG         4

// reset values
`define SPISD_RST_CTRL_ONE    8'h00
`define SPISD_RST_CTRL_TWO    8'h00
`define SPISD_RST_DATA_HIGH   8'h00
`define SPISD_RST_DATA_LOW    8'h00

// bits per transfer for each width setting
`define SPISD_BITS_NARROW     5'h08
`define SPISD_BITS_WIDE       5'h10

// clk cycles per half period of the generated serial clock
`define SPISD_HALF_DIV        8'h04

`endif

// *** verif/spi_status_and_data_buffer_bench.sv ***
/*
 * Self-checking bench for spisd_core with a serial slave partner.
 * Assumes the default half period of four clk cycles (800 ns link).
 */
`timescale 1ns/1ps
module spi_status_and_data_buffer_bench;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [2:0]  bus_addr = 3'h0;
    logic [7:0]  bus_wdata = 8'h00;
    logic        bus_wr = 1'b0;
    logic        bus_rd = 1'b0;
    logic        ss_n_in = 1'b1;
    logic        m_sck = 1'b0;
    logic        m_mosi = 1'b0;
    logic        wide = 1'b0;
    logic [15:0] tx_word = 16'h0000;
    logic [7:0]  v;
    wire  [7:0]  bus_rdata;
    wire         sck_out, sck_oe_n, mosi_out, mosi_oe_n;
    wire         miso_out, miso_oe_n, transfer_busy, m_miso;
    wire  [15:0] rx_word;
    wire  [3:0]  words;
    wire         sck_pin = sck_oe_n ? m_sck : sck_out;
    wire         mosi_pin = mosi_oe_n ? m_mosi : mosi_out;
    wire         miso_pin = miso_oe_n ? m_miso : miso_out;
    int          mismatches = 0;
    int          checks_done = 0;
    int          gap = 0;

    always #50 clk = ~clk;

    spisd_core DUT (.clk, .rst, .bus_addr, .bus_wdata, .bus_wr, .bus_rd,
        .bus_rdata, .sck_in(sck_pin), .sck_out, .sck_oe_n,
        .mosi_in(mosi_pin), .mosi_out, .mosi_oe_n, .miso_in(miso_pin),
        .miso_out, .miso_oe_n, .ss_n_in, .transfer_busy);
    spisd_slave_model partner (.sck(sck_pin), .sel_n(~transfer_busy),
        .mosi(mosi_pin), .wide, .tx_word, .miso(m_miso), .rx_word, .words);

    task automatic end_of_test;
        if (mismatches == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clk);
        bus_wr <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a);
        @(posedge clk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clk);
        bus_rd <= 1'b0;
        @(negedge clk);
        v = bus_rdata;
    endtask
    task automatic rchk(input string what, input logic [2:0] a,
                        input logic [7:0] exp);
        rd(a);
        chk(what, {8'h00, exp}, {8'h00, v});
    endtask
    // gap counts idle cycles between the last two words
    task automatic wait_done(input logic [3:0] n);
        int i;
        gap = 0;
        for (i = 0; i < 400 && (words !== n || transfer_busy); i++) begin
            @(posedge clk);
            if (words === n - 4'h1 && !transfer_busy) gap++;
        end
        if (i == 400) begin
            mismatches++;
            end_of_test();
        end
    endtask

    task automatic t_reset;
        rchk("status", 3'h3, 8'h20);
        rchk("data high", 3'h4, 8'h00);
        rchk("unmapped", 3'h2, 8'h00);
        @(posedge clk);
        bus_addr <= 3'h3;
        bus_rd <= 1'b1;
        @(posedge clk);
        bus_rd <= 1'b0;
        bus_wdata <= 8'hff;
        bus_wr <= 1'b1;
        @(posedge clk);
        bus_wr <= 1'b0;
        bus_rd <= 1'b1;
        @(posedge clk);
        bus_rd <= 1'b0;
        @(negedge clk);
        chk("status kept", 16'h0020, {8'h00, bus_rdata});
    endtask
    task automatic t_master8;
        wr(3'h0, 8'h50);
        tx_word <= 16'h003c;
        rchk("armed", 3'h3, 8'h20);
        wr(3'h5, 8'ha5);
        wait_done(4'h1);
        chk("sent", 16'h00a5, {8'h00, rx_word[7:0]});
        rchk("rcf set", 3'h3, 8'ha0);
        rchk("high", 3'h4, 8'h00);
        rchk("rcf kept", 3'h3, 8'ha0);
        rchk("low", 3'h5, 8'h3c);
        rchk("rcf clear", 3'h3, 8'h20);
    endtask
    task automatic t_held;
        tx_word <= 16'h0011;
        wr(3'h5, 8'h01);
        rd(3'h3);
        rd(3'h3);
        wr(3'h5, 8'h02);
        rchk("queued", 3'h3, 8'h00);
        wr(3'h4, 8'hff);
        wr(3'h5, 8'h77);
        tx_word <= 16'h0022;
        wait_done(4'h3);
        chk("idle gap", 16'h0001, {15'h0000, gap <= 2});
        chk("sent two", 16'h0102, rx_word);
        rchk("rcf", 3'h3, 8'ha0);
        rchk("first", 3'h5, 8'h11);
        rchk("rcf held", 3'h3, 8'ha0);
        rchk("second", 3'h5, 8'h22);
        rchk("rcf clear", 3'h3, 8'h20);
    endtask
    // second word is held, then the third start makes it stale
    task automatic t_late;
        tx_word <= 16'h00a1;
        wr(3'h5, 8'h0a);
        rd(3'h3);
        wr(3'h5, 8'h0b);
        tx_word <= 16'h00b2;
        wait_done(4'h4);
        rd(3'h3);
        wr(3'h5, 8'h0c);
        tx_word <= 16'h00c3;
        wait_done(4'h5);
        rchk("rcf late", 3'h3, 8'ha0);
        rchk("first late", 3'h5, 8'ha1);
        rchk("held dropped", 3'h3, 8'h20);
        wait_done(4'h6);
        chk("sent third", 16'h000c, {8'h00, rx_word[7:0]});
        rchk("third in", 3'h3, 8'ha0);
        rchk("third", 3'h5, 8'hc3);
    endtask
    task automatic t_wide;
        wr(3'h1, 8'h40);
        wide <= 1'b1;
        tx_word <= 16'hbeef;
        rd(3'h3);
        wr(3'h4, 8'h99);
        wr(3'h4, 8'h12);
        rchk("tef kept", 3'h3, 8'h20);
        wr(3'h5, 8'h34);
        wait_done(4'h7);
        chk("sent word", 16'h1234, rx_word);
        rchk("rcf", 3'h3, 8'ha0);
        rchk("high", 3'h4, 8'hbe);
        rchk("low", 3'h5, 8'hef);
    endtask
    task automatic t_fault;
        wr(3'h1, 8'h10);
        wide <= 1'b0;
        ss_n_in <= 1'b0;
        rd(3'h3);
        rchk("fault", 3'h3, 8'h30);
        chk("master off", 16'h0001, {15'h0000, mosi_oe_n});
        wr(3'h0, 8'h40);
        rchk("fault clear", 3'h3, 8'h20);
        ss_n_in <= 1'b1;
    endtask
    // block as slave: bench selects it and clocks 800 ns bits
    task automatic t_slave;
        logic [7:0] seen;
        logic [7:0] sent;
        seen = 8'h00;
        sent = 8'h5a;
        rd(3'h3);
        wr(3'h5, 8'hc3);
        ss_n_in <= 1'b0;
        repeat (4) @(posedge clk);
        for (int b = 7; b >= 0; b--) begin
            m_mosi <= sent[b];
            repeat (4) @(posedge clk);
            m_sck <= 1'b1;
            seen = {seen[6:0], miso_pin};
            repeat (4) @(posedge clk);
            m_sck <= 1'b0;
        end
        ss_n_in <= 1'b1;
        chk("slave sent", 16'h00c3, {8'h00, seen});
        rchk("slave rcf", 3'h3, 8'ha0);
        rchk("slave got", 3'h5, 8'h5a);
    endtask

    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_master8();
        t_held();
        t_late();
        t_wide();
        t_fault();
        t_slave();
        end_of_test();
    end
endmodule // spi_status_and_data_buffer_bench

// *** verif/spisd_properties.sv ***
/*
 * Port-level assertions for spisd_core, bound to every instance.
 * Assumes one-cycle register strobes and a master link in mode 0.
 */
`timescale 1ns/1ps
module spisd_checker #(
    parameter logic [7:0] HALF_DIV = 8'h04
) (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic [2:0] bus_addr,
    input wire logic       bus_wr,
    input wire logic       bus_rd,
    input wire logic [7:0] bus_rdata,
    input wire logic       sck_out,
    input wire logic       mosi_out,
    input wire logic       mosi_oe_n,
    input wire logic       ss_n_in,
    input wire logic       transfer_busy
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    logic [4:0] rises;
    logic [7:0] hi_len;
    logic       busy_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rises  <= 5'h00;
            hi_len <= 8'h00;
            busy_q <= 1'b0;
        end else begin
            rises  <= transfer_busy ? rises + {4'h0, $rose(sck_out)} : 5'h00;
            hi_len <= sck_out ? hi_len + 8'h01 : 8'h00;
            busy_q <= transfer_busy;
        end
    end

    sequence s_stat_rd;
        bus_rd && bus_addr == 3'h3;
    endsequence
    sequence s_high_rd;
        bus_rd && bus_addr == 3'h4;
    endsequence
    // no word may land meanwhile, else the flags move on their own
    sequence s_stat_rwr;
        s_stat_rd ##0 !busy_q && !transfer_busy && ss_n_in ##1
        bus_wr && bus_addr == 3'h3 && !transfer_busy && ss_n_in ##1
        s_stat_rd ##0 !transfer_busy && ss_n_in;
    endsequence

    a_unused_bits_zero: assert property (
        s_stat_rd |=> bus_rdata[6] == 1'b0 && bus_rdata[3:0] == 4'h0)
        else $error("unused status bits read nonzero");
    a_rdata_one_cycle: assert property (
        !bus_rd |=> bus_rdata == 8'h00)
        else $error("read data outside its cycle");
    a_high_keeps_flag: assert property (
        s_stat_rd ##1 bus_rdata[7] ##1 s_high_rd ##2 s_stat_rd
        |=> bus_rdata[7])
        else $error("high byte read cleared receive flag");
    a_status_write_kept: assert property (
        s_stat_rwr |=> bus_rdata == $past(bus_rdata, 2))
        else $error("status write changed flags");
    a_start_delay: assert property (
        $rose(transfer_busy) && !mosi_oe_n |-> !sck_out [*3])
        else $error("serial clock started without half period delay");
    a_sck_half_period: assert property (
        $fell(sck_out) |-> hi_len == HALF_DIV)
        else $error("serial clock high phase has wrong length");
    a_word_edges: assert property (
        $fell(transfer_busy) ##1 !mosi_oe_n
        |-> $past(rises) == 5'h08 || $past(rises) == 5'h10)
        else $error("transfer edge count is not 8 or 16");
    a_mosi_holds: assert property (
        sck_out && $past(sck_out) |-> $stable(mosi_out))
        else $error("data out moved while serial clock high");
endmodule // spisd_checker

bind spisd_core spisd_checker #(.HALF_DIV(HALF_DIV)) u_checker (
    .clk, .rst, .bus_addr, .bus_wr, .bus_rd, .bus_rdata, .sck_out,
    .mosi_out, .mosi_oe_n, .ss_n_in, .transfer_busy);

// *** verif/spisd_slave_model.sv ***
/*
 * Serial slave at the far end of the link: mode 0, MSB first.
 * Assumes its select follows the master's busy output.
 */
`timescale 1ns/1ps
module spisd_slave_model (
    input  logic        sck,
    input  logic        sel_n,
    input  logic        mosi,
    input  logic        wide,
    input  logic [15:0] tx_word,
    output logic        miso,
    output logic [15:0] rx_word,
    output logic [3:0]  words
);
    logic [15:0] shreg = 16'h0000;
    logic [4:0]  bits = 5'h00;
    logic        reload = 1'b0;

    initial words = 4'h0;
    initial rx_word = 16'h0000;
    // deselected: inverse level, so a stale bit is never taken as data
    assign miso = sel_n ? ~shreg[15] : shreg[15];

    always @(negedge sel_n) begin
        shreg = wide ? tx_word : {tx_word[7:0], 8'h00};
        bits = 5'h00;
    end
    always @(posedge sck) begin
        rx_word = {rx_word[14:0], mosi};
        bits = bits + 5'h01;
        if (bits == (wide ? 5'h10 : 5'h08)) begin
            bits = 5'h00;
            words = words + 4'h1;
            reload = 1'b1;
        end
    end
    // select may stay low across back-to-back words, so reload here
    always @(negedge sck) begin
        if (reload) shreg = wide ? tx_word : {tx_word[7:0], 8'h00};
        else shreg = {shreg[14:0], 1'b0};
        reload = 1'b0;
    end
endmodule // spisd_slave_model
